//--- hw/fsv_latch.sv
// fsv_latch: per-bit sticky fault latches, set wins over clear
// assumes set and clr are from ref_clk logic
`timescale 1ns/1ns
module fsv_latch #(
   parameter int W = 1
) (
   input wire logic ref_clk,        // system clock
   input wire logic rstn,           // sync reset, active low
   input wire logic [W-1:0] set,    // fault condition
   input wire logic [W-1:0] clr,    // clear permitted
   output logic [W-1:0] q           // latched faults
);
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         q <= '0;
      end else begin
         q <= set | (q & ~clr);
      end
   end
endmodule : fsv_latch

//--- hw/fsv_sync.sv
// fsv_sync: two-flop synchroniser for a vector of pin inputs
// assumes each bit is an independent level
`timescale 1ns/1ns
module fsv_sync #(
   parameter int W = 1
) (
   input wire logic ref_clk,        // system clock
   input wire logic rstn,           // sync reset, active low
   input wire logic [W-1:0] din,    // asynchronous levels
   output logic [W-1:0] dout        // synchronised levels
);
   logic [W-1:0] meta_q;
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         meta_q <= '0;
         dout <= '0;
      end else begin
         meta_q <= din;
         dout <= meta_q;
      end
   end
endmodule : fsv_sync

//--- hw/fsv_top.sv
// fsv_top: servo drive fault supervisor
// assumes sensor pins are asynchronous, firmware flags and the bus
// voltage word come from ref_clk logic, rstn is the logic power reset
//
// How it works
// - faults ranked fixed: flash, self-test, memory, config, overtemp ... run time
// - display shows only the code of the highest active fault
// - travel limits clear on their own and never disable the bridge
// - position keeps counting through every fault while logic power stays
// - bus high and similar faults clear by button or reset line
// - encoder faults clear on power cycle, or also by reset on one variant
// - firmware checksum failure raises fault, cleared only by reprogramming
// - failed self-test fault ignores reset requests, only power cycle clears
// - invalid nonvolatile memory raises fault cleared by reset request
// - board identity mismatch raises the invalid configuration fault
// - internal overtemp, or soft-start failure on large drives, clears once cool
// - power stage overtemp, overcurrent or supply loss raises power module fault
// - bus above 415 V raises the high bus fault
// - low bus raised after 50 ms continuously below 60 V
// - small drives may disable low bus monitoring, then no fault
// - large drives: low bus not disableable, auto clears at 140 V, 50 V drop recurs
`timescale 1ns/1ns
module fsv_top
   import fsv_pkg::*;
#(
   parameter int LOWBUS_DEB = LOWBUS_DEB_CYC,  // debounce cycles
   parameter bit VAR_ENC_RESET = 1'b0,         // encoder faults reset-clearable
   parameter bit VAR_LARGE = 1'b0              // large frame drive
) (
   input wire logic ref_clk,                 // system clock
   input wire logic rstn,                    // logic power reset
   // pins
   input wire logic reset_btn,               // front reset button
   input wire logic reset_line,              // reset input function
   input wire logic drv_ot_pin,              // internal overtemp
   input wire logic ss_fail_pin,             // soft-start failure
   input wire logic pm_ot_pin,               // power stage overtemp
   input wire logic pm_oc_pin,               // power stage overcurrent
   input wire logic pm_supply_lost_pin,      // power stage logic supply lost
   input wire logic enc_state_pin,           // bad encoder transition
   input wire logic enc_hw_pin,              // encoder line fault
   input wire logic mot_ot_pin,              // motor thermal switch open
   input wire logic travel_pos_pin,          // positive travel limit
   input wire logic travel_neg_pin,          // negative travel limit
   input wire logic enc_a_pin,               // encoder channel a
   input wire logic enc_b_pin,               // encoder channel b
   // firmware and measurement
   input wire logic fw_crc_bad,              // firmware checksum failed
   input wire logic fw_reprog_done,          // flash reprogrammed, pulse
   input wire logic post_fail,               // power-up self-test failed
   input wire logic nvm_bad,                 // nonvolatile memory invalid
   input wire logic [ID_W-1:0] dig_id,       // digital board identity
   input wire logic [ID_W-1:0] pwr_id,       // power board identity
   input wire logic [VOLT_W-1:0] bus_volts,  // bus voltage, volts
   input wire logic lowbus_mon_en,           // low bus monitoring enable
   input wire logic ss_done,                 // soft-start finished, pulse
   input wire logic shunt_fault,             // shunt power or short
   input wire logic overspeed,               // overspeed detected
   input wire logic follow_err,              // following error exceeded
   input wire logic sync_fault,              // trajectory sync fault
   input wire logic runtime_fault,           // run time fault
   // consumers
   output logic bridge_en_q,                 // power bridge enable
   output logic [CODE_W-1:0] disp_code_q,    // displayed fault code
   output logic fault_any_q,                 // any fault active
   output logic [FLT_N-1:0] fault_q,         // latched fault vector
   output logic signed [31:0] pos_q          // motor position count
);

   // ----------------------------------------
   // pin synchronisers
   // ----------------------------------------
   localparam int PIN_N = 14;
   logic [PIN_N-1:0] pin_raw;
   logic [PIN_N-1:0] pin_s;
   logic btn_s;
   logic line_s;
   logic drv_ot_s;
   logic ss_fail_s;
   logic pm_ot_s;
   logic pm_oc_s;
   logic pm_lost_s;
   logic enc_st_s;
   logic enc_hw_s;
   logic mot_ot_s;
   logic trav_p_s;
   logic trav_n_s;
   logic enc_a_s;
   logic enc_b_s;

   assign pin_raw = {reset_btn, reset_line, drv_ot_pin, ss_fail_pin,
                     pm_ot_pin, pm_oc_pin, pm_supply_lost_pin,
                     enc_state_pin, enc_hw_pin, mot_ot_pin,
                     travel_pos_pin, travel_neg_pin, enc_a_pin, enc_b_pin};

   fsv_sync #(.W(PIN_N)) u_sync (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .din(pin_raw),
      .dout(pin_s)
   );

   assign {btn_s, line_s, drv_ot_s, ss_fail_s, pm_ot_s, pm_oc_s, pm_lost_s,
           enc_st_s, enc_hw_s, mot_ot_s, trav_p_s, trav_n_s,
           enc_a_s, enc_b_s} = pin_s;

   // ----------------------------------------
   // reset request
   // ----------------------------------------
   logic rst_lvl;
   logic rst_lvl_q;
   logic rst_req_q;

   assign rst_lvl = btn_s | line_s;

   // one pulse per press of button or line
   // a held level asks once; release to ask again
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         rst_lvl_q <= 1'b0;
         rst_req_q <= 1'b0;
      end else begin
         rst_lvl_q <= rst_lvl;
         rst_req_q <= rst_lvl & ~rst_lvl_q;
      end
   end

   // ----------------------------------------
   // low bus debounce
   // ----------------------------------------
   logic [DEB_W-1:0] deb_cnt_q;
   logic bus_below;
   logic deb_done;
   logic mon_off;

   assign bus_below = bus_volts < BUS_LOW_V;
   assign deb_done = deb_cnt_q == DEB_W'(LOWBUS_DEB - 1);

   // small drives: monitor off holds the window at zero,
   // so enabling it never trips on a stale count
   assign mon_off = !VAR_LARGE && !lowbus_mon_en;

   // counts only while continuously below, restarts otherwise
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         deb_cnt_q <= DEB_RST;
      end else if (!bus_below || mon_off) begin
         deb_cnt_q <= DEB_RST;
      end else if (!deb_done) begin
         deb_cnt_q <= deb_cnt_q + DEB_W'(1);
      end
   end

   // ----------------------------------------
   // soft-start level capture
   // ----------------------------------------
   logic [VOLT_W-1:0] ss_level_q;
   logic ss_valid_q;
   logic bus_dropped;

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         ss_level_q <= SS_LEVEL_RST;
         ss_valid_q <= 1'b0;
      end else if (ss_done) begin
         ss_level_q <= bus_volts;
         ss_valid_q <= 1'b1;
      end
   end

   // widened sum avoids wrap near full scale
   assign bus_dropped = ss_valid_q &&
      ({1'b0, bus_volts} + {1'b0, BUS_DROP_V} < {1'b0, ss_level_q});

   // ----------------------------------------
   // fault conditions
   // ----------------------------------------
   logic [FLT_N-1:0] cond;
   logic lowbus_cond;

   // large drives ignore the monitor enable
   always_comb begin
      if (VAR_LARGE) begin
         lowbus_cond = deb_done | bus_dropped;
      end else begin
         lowbus_cond = deb_done & lowbus_mon_en;
      end
   end

   always_comb begin
      cond = FAULT_RST;
      cond[F_FLASH] = fw_crc_bad;
      cond[F_POST] = post_fail;
      cond[F_NVM] = nvm_bad;
      cond[F_CONFIG] = dig_id != pwr_id;
      cond[F_DRV_OT] = drv_ot_s | (VAR_LARGE & ss_fail_s);
      cond[F_PWR_MOD] = pm_ot_s | pm_oc_s | pm_lost_s;
      cond[F_BUS_HI] = bus_volts > BUS_HIGH_V;
      cond[F_BUS_LO] = lowbus_cond;
      cond[F_ENC_ST] = enc_st_s;
      cond[F_ENC_HW] = enc_hw_s;
      cond[F_MOT_OT] = mot_ot_s;
      cond[F_SHUNT] = shunt_fault;
      cond[F_OVSPD] = overspeed;
      cond[F_FOLLOW] = follow_err;
      cond[F_TRAVEL] = trav_p_s | trav_n_s;
      cond[F_SYNC] = sync_fault;
      cond[F_RUNTIME] = runtime_fault;
   end

   // ----------------------------------------
   // clear policy per fault
   // ----------------------------------------
   logic [FLT_N-1:0] clr;

   // a clear is a permission only; a live condition still sets
   always_comb begin
      clr = FAULT_RST;
      clr[F_FLASH] = fw_reprog_done;
      clr[F_POST] = 1'b0;
      clr[F_NVM] = rst_req_q;
      clr[F_CONFIG] = rst_req_q;
      clr[F_DRV_OT] = ~drv_ot_s & ~(VAR_LARGE & ss_fail_s);
      clr[F_PWR_MOD] = rst_req_q;
      clr[F_BUS_HI] = rst_req_q;
      if (VAR_LARGE) begin
         clr[F_BUS_LO] = bus_volts >= BUS_RECOVER_V;
      end else begin
         clr[F_BUS_LO] = rst_req_q;
      end
      clr[F_ENC_ST] = VAR_ENC_RESET & rst_req_q;
      clr[F_ENC_HW] = VAR_ENC_RESET & rst_req_q;
      clr[F_MOT_OT] = rst_req_q & ~mot_ot_s;
      clr[F_SHUNT] = rst_req_q;
      clr[F_OVSPD] = rst_req_q;
      clr[F_FOLLOW] = rst_req_q;
      clr[F_TRAVEL] = ~cond[F_TRAVEL];
      clr[F_SYNC] = 1'b0;
      clr[F_RUNTIME] = rst_req_q;
   end

   // ----------------------------------------
   // fault latches
   // ----------------------------------------
   logic [FLT_N-1:0] latched;

   // set wins over clear; others hold until their own clear
   fsv_latch #(.W(FLT_N)) u_latch (
      .ref_clk(ref_clk),
      .rstn(rstn),
      .set(cond),
      .clr(clr),
      .q(latched)
   );

   // ----------------------------------------
   // priority encoder
   // ----------------------------------------
   logic [CODE_W-1:0] top_code;

   // scan lowest first so highest active wins
   always_comb begin
      top_code = CODE_NONE;
      for (int i = FLT_N - 1; i >= 0; i--) begin
         if (latched[i]) begin
            top_code = CODE_W'(i + 1);
         end
      end
   end

   // ----------------------------------------
   // bridge and display outputs
   // ----------------------------------------
   logic [FLT_N-1:0] bridge_mask;

   // travel stops motion upstream; the bridge stays up
   always_comb begin
      bridge_mask = ~FAULT_RST;
      bridge_mask[F_TRAVEL] = 1'b0;
   end

   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         bridge_en_q <= 1'b0;
      end else begin
         bridge_en_q <= ~|(latched & bridge_mask);
      end
   end

   // all outputs one edge behind the latches
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         disp_code_q <= CODE_NONE;
         fault_any_q <= 1'b0;
         fault_q <= FAULT_RST;
      end else begin
         disp_code_q <= top_code;
         fault_any_q <= |latched;
         fault_q <= latched;
      end
   end

   // ----------------------------------------
   // position tracking
   // ----------------------------------------
   logic [1:0] quad_q;
   logic [1:0] quad_now;
   logic step_up;
   logic step_dn;

   assign quad_now = {enc_a_s, enc_b_s};

   // gray sequence 00 01 11 10 counts up
   always_comb begin
      step_up = 1'b0;
      step_dn = 1'b0;
      case ({quad_q, quad_now})
         4'b0001, 4'b0111, 4'b1110, 4'b1000: step_up = 1'b1;
         4'b0010, 4'b1011, 4'b1101, 4'b0100: step_dn = 1'b1;
         // no step, or a skipped state: hold
         default: begin
            step_up = 1'b0;
            step_dn = 1'b0;
         end
      endcase
   end

   // independent of fault state; only logic power reset stops it
   always_ff @(posedge ref_clk) begin
      if (!rstn) begin
         quad_q <= 2'b00;
         pos_q <= POS_RST;
      end else begin
         quad_q <= quad_now;
         if (step_up) begin
            pos_q <= pos_q + 32'sd1;
         end else if (step_dn) begin
            pos_q <= pos_q - 32'sd1;
         end
      end
   end

endmodule : fsv_top

//--- pkg/fsv_pkg.sv
// fsv_pkg: constants shared by the servo fault supervisor files
// assumes a 100 MHz ref_clk and bus voltage delivered in whole volts
package fsv_pkg;
   // ----------------------------------------
   // clock and timing
   // ----------------------------------------
   localparam int CLK_HZ = 100_000_000;
   localparam int LOWBUS_DEB_MS = 50;
   localparam int LOWBUS_DEB_CYC = LOWBUS_DEB_MS * (CLK_HZ / 1000);
   localparam int DEB_W = 23;
   // ----------------------------------------
   // bus voltage thresholds, volts
   // ----------------------------------------
   localparam int VOLT_W = 10;
   localparam logic [9:0] BUS_HIGH_V = 10'h19f;    // 415
   localparam logic [9:0] BUS_LOW_V = 10'h03c;     // 60
   localparam logic [9:0] BUS_RECOVER_V = 10'h08c; // 140
   localparam logic [9:0] BUS_DROP_V = 10'h032;    // 50
   // ----------------------------------------
   // fault indices, highest priority first
   // ----------------------------------------
   localparam int FLT_N = 17;
   localparam int F_FLASH = 0;
   localparam int F_POST = 1;
   localparam int F_NVM = 2;
   localparam int F_CONFIG = 3;
   localparam int F_DRV_OT = 4;
   localparam int F_PWR_MOD = 5;
   localparam int F_BUS_HI = 6;
   localparam int F_BUS_LO = 7;
   localparam int F_ENC_ST = 8;
   localparam int F_ENC_HW = 9;
   localparam int F_MOT_OT = 10;
   localparam int F_SHUNT = 11;
   localparam int F_OVSPD = 12;
   localparam int F_FOLLOW = 13;
   localparam int F_TRAVEL = 14;
   localparam int F_SYNC = 15;
   localparam int F_RUNTIME = 16;
   // ----------------------------------------
   // display codes and reset values
   // ----------------------------------------
   localparam int CODE_W = 5;
   localparam logic [4:0] CODE_NONE = 5'h00;
   localparam logic [16:0] FAULT_RST = 17'h00000;
   localparam logic [31:0] POS_RST = 32'h00000000;
   localparam logic [9:0] SS_LEVEL_RST = 10'h000;
   localparam logic [22:0] DEB_RST = 23'h000000;
   localparam int ID_W = 8;
endpackage : fsv_pkg

//--- verif/fsv_asserts.sv
// fsv_asserts: port timing checks for fsv_top
// assumes one clock domain; LARGE follows the drive variant
`timescale 1ns/1ns
module fsv_asserts
   import fsv_pkg::*;
#(
   parameter int LOWBUS_DEB = 8,
   parameter bit LARGE = 1'b0
) (
   input wire logic ref_clk, // clock
   input wire logic rstn, // reset
   input wire logic travel_pos_pin, // limit +
   input wire logic travel_neg_pin, // limit -
   input wire logic enc_a_pin, // enc a
   input wire logic enc_b_pin, // enc b
   input wire logic fw_crc_bad, // checksum bad
   input wire logic nvm_bad, // memory bad
   input wire logic [ID_W-1:0] dig_id, // id
   input wire logic [ID_W-1:0] pwr_id, // id
   input wire logic [VOLT_W-1:0] bus_volts, // volts
   input wire logic lowbus_mon_en, // monitor on
   input wire logic bridge_en_q, // bridge
   input wire logic [CODE_W-1:0] disp_code_q, // code
   input wire logic [FLT_N-1:0] fault_q, // faults
   input wire logic signed [31:0] pos_q // position
);
   localparam logic [16:0] NON_TRAVEL = 17'h1bfff;
   logic [CODE_W-1:0] top_code;
   logic [22:0] low_cnt;
   logic low_now;
   logic qual_q;
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rstn);
   assign low_now = (LARGE || lowbus_mon_en) && (bus_volts < BUS_LOW_V);
   always_comb begin
      top_code = CODE_NONE;
      for (int i = FLT_N - 1; i >= 0; i--) begin
         if (fault_q[i]) top_code = CODE_W'(i + 1);
      end
   end
   // consecutive monitored low samples
   always_ff @(posedge ref_clk) begin
      if (!rstn || !low_now) low_cnt <= DEB_RST;
      else if (low_cnt != 23'h7fffff) low_cnt <= low_cnt + 23'h000001;
   end
   // a full debounce window has been seen
   always_ff @(posedge ref_clk) begin
      if (!rstn) qual_q <= 1'b0;
      else if (low_now && low_cnt >= 23'(LOWBUS_DEB - 1)) qual_q <= 1'b1;
      else if (fault_q[F_BUS_LO]) qual_q <= 1'b0;
   end
   sequence travel_quiet;
      (!travel_pos_pin && !travel_neg_pin) [*6];
   endsequence
   sequence enc_quiet;
      ($stable(enc_a_pin) && $stable(enc_b_pin)) [*5];
   endsequence
   AST_PRIO: assert property (disp_code_q == top_code)
      else $error("display not top fault");
   AST_BRIDGE_OFF: assert property ((fault_q & NON_TRAVEL) != '0 |-> !bridge_en_q)
      else $error("bridge on during fault");
   AST_BRIDGE_TRAVEL: assert property ($past(rstn) && (fault_q & NON_TRAVEL) == '0 |-> bridge_en_q)
      else $error("bridge off without fault");
   AST_TRAVEL_CLR: assert property (travel_quiet |-> !fault_q[F_TRAVEL])
      else $error("travel fault not cleared");
   AST_FLASH: assert property (fw_crc_bad |-> ##[1:2] fault_q[F_FLASH])
      else $error("flash fault missing");
   AST_POST_HOLD: assert property (fault_q[F_POST] |=> fault_q[F_POST])
      else $error("self-test fault dropped");
   AST_NVM: assert property (nvm_bad |-> ##[1:2] fault_q[F_NVM])
      else $error("memory fault missing");
   AST_CONFIG: assert property (dig_id != pwr_id |-> ##[1:2] fault_q[F_CONFIG])
      else $error("config fault missing");
   AST_BUS_HI: assert property (bus_volts > BUS_HIGH_V |-> ##[1:2] fault_q[F_BUS_HI])
      else $error("high bus fault missing");
   AST_LOWBUS: assert property ($rose(fault_q[F_BUS_LO]) |-> qual_q)
      else $error("low bus fault too early");
   AST_POS: assert property (enc_quiet |-> $stable(pos_q))
      else $error("position moved without step");
endmodule : fsv_asserts
bind fsv_top fsv_asserts #(.LOWBUS_DEB(LOWBUS_DEB), .LARGE(VAR_LARGE)) u_asserts (.*);

//--- verif/fsv_bridge_model.sv
// fsv_bridge_model: power bridge and display as consumers
// assumes registered ref_clk outputs of fsv_top
`timescale 1ns/1ns
module fsv_bridge_model
   import fsv_pkg::*;
(
   input wire logic ref_clk, // clock
   input wire logic rstn, // reset
   input wire logic bridge_en_q, // bridge enable
   input wire logic [CODE_W-1:0] disp_code_q, // code to show
   output logic [15:0] trip_cnt, // bridge drops seen
   output logic [CODE_W-1:0] shown_code // code on display
);
   logic en_last;
   always_ff @(posedge ref_clk) begin
      en_last <= bridge_en_q;
      shown_code <= disp_code_q;
      if (!rstn) trip_cnt <= 16'h0000;
      else if (en_last && !bridge_en_q) trip_cnt <= trip_cnt + 16'h0001;
   end
endmodule : fsv_bridge_model

//--- verif/test_servo_drive_fault_supervisor.sv
// test_servo_drive_fault_supervisor: scenario bench for fsv_top
// assumes a short low bus debounce; dut_big_u is the large variant
`timescale 1ns/1ns
module test_servo_drive_fault_supervisor
   import fsv_pkg::*;
;
   localparam int DEB = 8;
   logic ref_clk, rstn, reset_btn, reset_line, drv_ot_pin, ss_fail_pin, pm_ot_pin, pm_oc_pin;
   logic pm_supply_lost_pin, enc_state_pin, enc_hw_pin, mot_ot_pin, travel_pos_pin, travel_neg_pin;
   logic enc_a_pin, enc_b_pin, fw_crc_bad, fw_reprog_done, post_fail, nvm_bad, lowbus_mon_en, ss_done;
   logic shunt_fault, overspeed, follow_err, sync_fault, runtime_fault, bridge_en_q, fault_any_q;
   logic [ID_W-1:0] dig_id, pwr_id;
   logic [VOLT_W-1:0] bus_volts;
   logic [CODE_W-1:0] disp_code_q, shown_code;
   logic [FLT_N-1:0] fault_q;
   logic signed [31:0] pos_q;
   logic [15:0] trip_cnt;
   logic big_bridge;
   logic [FLT_N-1:0] big_fault;
   int err_count = 0;
   int total_checks = 0;
   fsv_top #(.LOWBUS_DEB(DEB)) dut_u (.*);
   fsv_top #(.LOWBUS_DEB(DEB), .VAR_ENC_RESET(1'b1), .VAR_LARGE(1'b1)) dut_big_u (
      .*, .bridge_en_q(big_bridge), .disp_code_q(), .fault_any_q(), .fault_q(big_fault), .pos_q());
   fsv_bridge_model u_model (.*);
   initial begin
      ref_clk = 1'b0;
      forever #5 ref_clk = ~ref_clk;
   end
   // ---------------------------------
   // helpers
   // ---------------------------------
   task automatic chk_vec(input string what, input logic [31:0] exp, input logic [31:0] got);
      total_checks++;
      if (got !== exp) begin
         err_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk_vec
   task automatic summarize();
      $display("checks %0d mismatches %0d", total_checks, err_count);
      if (err_count == 0 && total_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask : summarize
   task automatic cyc(input int n);
      repeat (n) @(negedge ref_clk);
   endtask : cyc
   task automatic wait_bit(input int idx, input logic v);
      int n;
      n = 0;
      while (fault_q[idx] !== v && n < 20) begin
         cyc(1);
         n++;
      end
      chk_vec("fault bit", 32'(v), 32'(fault_q[idx]));
      if (n == 20) summarize();
   endtask : wait_bit
   task automatic do_reset();
      cyc(1);
      rstn = 1'b0;
      cyc(20);
      rstn = 1'b1;
      cyc(3);
   endtask : do_reset
   task automatic press(input logic use_line);
      if (use_line) reset_line = 1'b1;
      else reset_btn = 1'b1;
      cyc(4);
      {reset_line, reset_btn} = 2'h0;
      cyc(4);
   endtask : press
   task automatic step(input logic [1:0] ab);
      {enc_a_pin, enc_b_pin} = ab;
      cyc(5);
   endtask : step
   task automatic reprog();
      fw_reprog_done = 1'b1;
      cyc(1);
      fw_reprog_done = 1'b0;
   endtask : reprog
   task automatic set_cond(input int idx, input logic v);
      case (idx)
         F_FLASH: fw_crc_bad = v;
         F_POST: post_fail = v;
         F_NVM: nvm_bad = v;
         F_CONFIG: pwr_id = v ? 8'ha5 : 8'h5a;
         F_DRV_OT: drv_ot_pin = v;
         F_PWR_MOD: pm_oc_pin = v;
         F_BUS_HI: bus_volts = v ? 10'h1a0 : 10'h12c;
         F_ENC_ST: enc_state_pin = v;
         F_ENC_HW: enc_hw_pin = v;
         F_MOT_OT: mot_ot_pin = v;
         F_SHUNT: shunt_fault = v;
         F_OVSPD: overspeed = v;
         F_FOLLOW: follow_err = v;
         F_SYNC: sync_fault = v;
         F_RUNTIME: runtime_fault = v;
         17: pm_ot_pin = v;
         default: pm_supply_lost_pin = v;
      endcase
   endtask : set_cond
   // ---------------------------------
   // scenarios
   // ---------------------------------
   task automatic t_prio();
      set_cond(F_OVSPD, 1'b1);
      wait_bit(F_OVSPD, 1'b1);
      chk_vec("code", 32'(F_OVSPD + 1), 32'(disp_code_q));
      set_cond(F_FLASH, 1'b1);
      wait_bit(F_FLASH, 1'b1);
      set_cond(F_NVM, 1'b1);
      wait_bit(F_NVM, 1'b1);
      chk_vec("shown", 32'h1, 32'(shown_code));
      set_cond(F_OVSPD, 1'b0);
      set_cond(F_FLASH, 1'b0);
      set_cond(F_NVM, 1'b0);
      reprog();
      wait_bit(F_FLASH, 1'b0);
      chk_vec("code", 32'(F_NVM + 1), 32'(disp_code_q));
      press(1'b0);
      chk_vec("faults", 32'h0, 32'(fault_q));
      chk_vec("code", 32'h0, 32'(disp_code_q));
      $display("test priority done");
   endtask : t_prio
   task automatic t_clearable();
      int ids[12] = '{F_NVM, F_CONFIG, F_DRV_OT, F_PWR_MOD, 17, 18, F_BUS_HI, F_MOT_OT, F_SHUNT, F_OVSPD,
                     F_FOLLOW, F_RUNTIME};
      int b;
      foreach (ids[k]) begin
         b = (ids[k] > 16) ? F_PWR_MOD : ids[k];
         set_cond(ids[k], 1'b1);
         wait_bit(b, 1'b1);
         chk_vec("code", 32'(b + 1), 32'(disp_code_q));
         chk_vec("bridge", 32'h0, 32'(bridge_en_q));
         set_cond(ids[k], 1'b0);
         if (b != F_DRV_OT) begin
            cyc(8);
            chk_vec("held", 32'h1, 32'(fault_q[b]));
            press(k[0]);
         end
         wait_bit(b, 1'b0);
         chk_vec("bridge", 32'h1, 32'(bridge_en_q));
      end
      $display("test clearable done");
   endtask : t_clearable
   task automatic t_travel();
      logic [15:0] t0;
      for (int s = 0; s < 2; s++) begin
         t0 = trip_cnt;
         travel_pos_pin = (s == 0);
         travel_neg_pin = (s == 1);
         wait_bit(F_TRAVEL, 1'b1);
         chk_vec("code", 32'(F_TRAVEL + 1), 32'(disp_code_q));
         chk_vec("any", 32'h1, 32'(fault_any_q));
         cyc(3);
         chk_vec("trips", 32'(t0), 32'(trip_cnt));
         {travel_pos_pin, travel_neg_pin} = 2'h0;
         wait_bit(F_TRAVEL, 1'b0);
      end
      $display("test travel done");
   endtask : t_travel
   task automatic t_lowbus();
      lowbus_mon_en = 1'b0;
      bus_volts = BUS_HIGH_V;
      cyc(8);
      chk_vec("bus high", 32'h0, 32'(fault_q[F_BUS_HI]));
      bus_volts = 10'h00a;
      cyc(20);
      chk_vec("low off", 32'h0, 32'(fault_q[F_BUS_LO]));
      lowbus_mon_en = 1'b1;
      cyc(DEB - 2);
      bus_volts = BUS_LOW_V;
      cyc(6);
      chk_vec("low short", 32'h0, 32'(fault_q[F_BUS_LO]));
      bus_volts = 10'h00a;
      wait_bit(F_BUS_LO, 1'b1);
      bus_volts = 10'h12c;
      press(1'b1);
      wait_bit(F_BUS_LO, 1'b0);
      $display("test low bus done");
   endtask : t_lowbus
   task automatic t_sticky();
      int ids[5] = '{F_FLASH, F_POST, F_SYNC, F_ENC_ST, F_ENC_HW};
      logic signed [31:0] p0;
      foreach (ids[k]) begin
         set_cond(ids[k], 1'b1);
         wait_bit(ids[k], 1'b1);
         set_cond(ids[k], 1'b0);
         press(1'b0);
         press(1'b1);
         chk_vec("held", 32'h1, 32'(fault_q[ids[k]]));
         if (ids[k] == F_FLASH) begin
            reprog();
            wait_bit(F_FLASH, 1'b0);
         end else begin
            p0 = pos_q;
            step(2'b01);
            step(2'b11);
            step(2'b10);
            step(2'b00);
            chk_vec("pos", 32'h4, 32'(pos_q - p0));
            do_reset();
            chk_vec("cleared", 32'h0, 32'(fault_q));
         end
      end
      $display("test sticky done");
   endtask : t_sticky
   task automatic t_large();
      set_cond(F_ENC_ST, 1'b1);
      cyc(6);
      set_cond(F_ENC_ST, 1'b0);
      press(1'b0);
      chk_vec("big enc", 32'h0, 32'(big_fault[F_ENC_ST]));
      lowbus_mon_en = 1'b0;
      bus_volts = 10'h00a;
      cyc(DEB + 4);
      chk_vec("big low", 32'h1, 32'(big_fault[F_BUS_LO]));
      chk_vec("big bridge", 32'h0, 32'(big_bridge));
      bus_volts = BUS_RECOVER_V - 10'h001;
      cyc(4);
      chk_vec("big held", 32'h1, 32'(big_fault[F_BUS_LO]));
      bus_volts = BUS_RECOVER_V;
      cyc(4);
      chk_vec("big clr", 32'h0, 32'(big_fault[F_BUS_LO]));
      $display("test large done");
   endtask : t_large
   // ---------------------------------
   // main sequence
   // ---------------------------------
   initial begin
      rstn = 1'b0;
      {reset_btn, reset_line, drv_ot_pin, ss_fail_pin, pm_ot_pin, pm_oc_pin, pm_supply_lost_pin} = '0;
      {enc_state_pin, enc_hw_pin, mot_ot_pin, travel_pos_pin, travel_neg_pin, enc_a_pin, enc_b_pin} = '0;
      {fw_crc_bad, fw_reprog_done, post_fail, nvm_bad, ss_done, shunt_fault, overspeed} = '0;
      {follow_err, sync_fault, runtime_fault} = '0;
      lowbus_mon_en = 1'b1;
      dig_id = 8'h5a;
      pwr_id = 8'h5a;
      bus_volts = 10'h12c;
      do_reset();
      chk_vec("idle", 32'h0, 32'(fault_q));
      chk_vec("any", 32'h0, 32'(fault_any_q));
      chk_vec("bridge", 32'h1, 32'(bridge_en_q));
      t_prio();
      t_clearable();
      t_travel();
      t_lowbus();
      t_sticky();
      t_large();
      summarize();
   end
endmodule : test_servo_drive_fault_supervisor
